// *** hdl/mac_status_top.sv ***
// MAC event status, shared-memory layout registers and transmit status.
// Assumes APB master on pclk; MAC engine event pulses on pclk; PHY
// management done, collision and carrier arrive asynchronously.
//
// Notes on behaviour
// - Transmit engine fault sets event bit seven
// - Management transfer completion sets event bit six
// - Overrun sets bit two; drop packets until cleared
// - Control frame sent sets event bit one
// - Packet sent sets event bit zero
// - Packet received sets event bit five
// - Pause packet received sets event bit four
// - Reception complete sets event bit three
// - Three pointers split shared memory areas
// - Buffer size 32..256 from bits seven, six
// - Descriptor precedes each packet in memory
// - Next pointer is 24-bit descriptor address
// - Byte count includes FCS, excludes descriptor
// - Status bit fifteen marks MAC ownership
// - Bit fourteen dropped, bit thirteen backpressure
// - Bit twelve when count exceeds maximum
// - Bit eleven when length field exceeds 1518
// - Bit ten when length disagrees with data
// - Bit nine on bad FCS without append
// - Bit eight deferred, seven excess deferral
// - Bit six on FIFO underrun
// - Late collision beyond limit sets bit five
// - Count collisions; over limit aborts, bit four
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mac_status_top
  import mac_status_pkg::*;
#(
  parameter int DEFER_100 = DEFER_CYC_100,
  parameter int DEFER_10 = DEFER_CYC_10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_fault_pulse,
  input wire logic mgmt_done_pin,
  input wire logic tx_ctrl_sent_pulse,
  input wire logic rx_ctrl_done_pulse,
  input wire logic rx_pause_pulse,
  input wire logic rx_packet_pulse,
  input wire logic rx_fifo_full_pulse,
  input wire logic tx_start_pulse,
  input wire logic [15:0] tx_byte_count,
  input wire logic [15:0] tx_len_type,
  input wire logic [15:0] tx_data_bytes,
  input wire logic tx_fcs_ok,
  input wire logic tx_byte_pulse,
  input wire logic tx_underrun_pulse,
  input wire logic tx_backpressure_pulse,
  input wire logic speed_100,
  input wire logic carrier_pin,
  input wire logic collision_pin,
  input wire logic tx_end_pulse,
  output logic irq_q,
  output logic rx_discard_q,
  output logic tx_retry_q,
  output logic tx_done_q,
  output logic [15:0] tx_status_q,
  output logic [1:0] buf_size_sel_q,
  output logic [8:0] buf_bytes_q,
  output logic [23:0] tx_area_start_pointer,
  output logic [23:0] rx_area_start_pointer,
  output logic [23:0] rx_area_end_pointer
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] pins_s;
  logic mgmt_s_q;
  pin_sync #(.WIDTH(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({mgmt_done_pin, carrier_pin, collision_pin}),
    .sync_out(pins_s)
  );
  wire mgmt_s = pins_s[2];
  wire carrier_s = pins_s[1];
  wire coll_s = pins_s[0];
  wire mgmt_rise = mgmt_s & ~mgmt_s_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] buf_size_q;
  logic [15:0] max_frame_q;
  logic [5:0] late_limit_q;
  logic [3:0] coll_limit_q;
  logic auto_fcs_append;
  logic [7:0] ev_flags;
  logic ev_any;
  logic [7:0] ev_set;
  logic [7:0] ev_clear;

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire hit_ev = paddr == OFF_EVENT_STATUS;
  wire hit_txs = paddr == OFF_AREA_TX_START;
  wire hit_rxs = paddr == OFF_AREA_RX_START;
  wire hit_rxe = paddr == OFF_AREA_RX_END;
  wire hit_bsz = paddr == OFF_BUF_SIZE;
  wire hit_max = paddr == OFF_MAX_FRAME;
  wire hit_c2 = paddr == OFF_CONFIG_TWO;
  wire hit_c3 = paddr == OFF_CONFIG_THREE;
  wire hit_ts = paddr == OFF_TX_STATUS;
  wire hit_fcs = paddr == OFF_AUTO_FCS;
  wire hit_any = hit_ev | hit_txs | hit_rxs | hit_rxe | hit_bsz | hit_max | hit_c2
               | hit_c3 | hit_ts | hit_fcs;

  // Read data selection
  wire [31:0] rd_mux =
      hit_ev ? {24'h000000, ev_flags} :
      hit_txs ? {8'h00, tx_area_start_pointer} :
      hit_rxs ? {8'h00, rx_area_start_pointer} :
      hit_rxe ? {8'h00, rx_area_end_pointer} :
      hit_bsz ? {24'h000000, buf_size_q} :
      hit_max ? {16'h0000, max_frame_q} :
      hit_c2 ? {26'h0000000, late_limit_q} :
      hit_c3 ? {28'h0000000, coll_limit_q} :
      hit_ts ? {16'h0000, tx_status_q} :
      hit_fcs ? {31'h00000000, auto_fcs_append} : 32'h00000000;

  // Write one to clear event bits
  assign ev_clear = (wr_en & hit_ev) ? pwdata[7:0] : 8'h00;

  wire [1:0] bsel = buf_size_q[BUF_SIZE_LSB+1:BUF_SIZE_LSB];
  wire [8:0] bbytes = 9'h020 << bsel;

  // Configuration register writes; APB answers with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_area_start_pointer <= RST_POINTER;
      rx_area_start_pointer <= RST_POINTER;
      rx_area_end_pointer <= RST_POINTER;
      buf_size_q <= RST_BUF_SIZE;
      max_frame_q <= RST_MAX_FRAME;
      late_limit_q <= RST_LATE_LIMIT;
      coll_limit_q <= RST_COLL_LIMIT;
      auto_fcs_append <= 1'b1;
    end else if (wr_en) begin
      if (hit_txs) tx_area_start_pointer <= pwdata[23:0];
      if (hit_rxs) rx_area_start_pointer <= pwdata[23:0];
      if (hit_rxe) rx_area_end_pointer <= pwdata[23:0];
      if (hit_bsz) buf_size_q <= pwdata[7:0];
      if (hit_max) max_frame_q <= pwdata[15:0];
      if (hit_c2) late_limit_q <= pwdata[5:0];
      if (hit_c3) coll_limit_q <= pwdata[3:0];
      if (hit_fcs) auto_fcs_append <= pwdata[0];
    end
  end

  // Bus answer and registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mgmt_s_q <= 1'b0;
      buf_size_sel_q <= 2'h0;
      buf_bytes_q <= 9'h000;
      irq_q <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
      mgmt_s_q <= mgmt_s;
      buf_size_sel_q <= bsel;
      buf_bytes_q <= bbytes;
      irq_q <= ev_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status flags
  // Event set sources
  assign ev_set[EV_TX_FAULT] = tx_fault_pulse;
  assign ev_set[EV_MGMT_DONE] = mgmt_rise;
  assign ev_set[EV_RX_OVERRUN] = rx_fifo_full_pulse;
  assign ev_set[EV_TX_CTRL] = tx_ctrl_sent_pulse;
  assign ev_set[EV_TX_DONE] = tx_done_q;
  assign ev_set[EV_RX_PACKET] = rx_packet_pulse;
  assign ev_set[EV_RX_PAUSE] = rx_pause_pulse;
  assign ev_set[EV_RX_DONE] = rx_ctrl_done_pulse;

  event_flags #(.WIDTH(8)) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(ev_set),
    .clear_mask(ev_clear),
    .flags_q(ev_flags),
    .any_q(ev_any)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_discard_q <= 1'b0;
    else rx_discard_q <= ev_flags[EV_RX_OVERRUN] | rx_fifo_full_pulse;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit descriptor status
  tx_state_type state_q;
  logic [31:0] defer_cnt_q;
  logic [15:0] sent_q;
  logic coll_s_q;
  wire coll_rise = coll_s & ~coll_s_q;
  wire [31:0] defer_lim = speed_100 ? 32'(DEFER_100) : 32'(DEFER_10);
  wire late_coll = sent_q > {10'h000, late_limit_q};
  wire [3:0] coll_next = tx_status_q[3:0] + 4'h1;
  // Count one wider so a limit of fifteen can still be exceeded
  wire [4:0] coll_wide = {1'b0, tx_status_q[3:0]} + 5'h01;
  wire coll_over = coll_wide > {1'b0, coll_limit_q};

  // Send/defer sequencing and status capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TX_IDLE;
      tx_status_q <= 16'h0000;
      defer_cnt_q <= 32'h00000000;
      sent_q <= 16'h0000;
      coll_s_q <= 1'b0;
      tx_retry_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else begin
      coll_s_q <= coll_s;
      tx_retry_q <= 1'b0;
      tx_done_q <= 1'b0;
      unique case (state_q)
        TX_IDLE: begin
          if (tx_start_pulse) begin
            tx_status_q <= 16'h0000;
            tx_status_q[TS_OWNER] <= 1'b1;
            tx_status_q[TS_OVERSIZE] <= tx_byte_count > max_frame_q;
            tx_status_q[TS_LEN_RANGE] <= tx_len_type > LEN_TYPE_MAX;
            // Length mismatch, only for a length field
            tx_status_q[TS_LEN_MISMATCH] <= (tx_len_type <= LEN_TYPE_MAX) &&
                                            (tx_len_type != tx_data_bytes);
            tx_status_q[TS_BAD_FCS] <= ~auto_fcs_append & ~tx_fcs_ok;
            defer_cnt_q <= 32'h00000000;
            sent_q <= 16'h0000;
            state_q <= carrier_s ? TX_DEFER : TX_SEND;
          end
        end
        TX_DEFER: begin
          tx_status_q[TS_DEFERRED] <= 1'b1;
          defer_cnt_q <= defer_cnt_q + 32'h00000001;
          if (defer_cnt_q >= defer_lim) tx_status_q[TS_EXCESS_DEFER] <= 1'b1;
          if (!carrier_s) state_q <= TX_SEND;
        end
        TX_SEND: begin
          if (tx_byte_pulse) sent_q <= sent_q + 16'h0001;
          if (tx_backpressure_pulse) tx_status_q[TS_BACKPRESSURE] <= 1'b1;
          if (coll_rise) begin
            tx_status_q[3:0] <= coll_next;
            if (late_coll) begin
              tx_status_q[TS_LATE_COLL] <= 1'b1;
              tx_status_q[TS_DROPPED] <= 1'b1;
              tx_status_q[TS_OWNER] <= 1'b0;
              tx_done_q <= 1'b1;
              state_q <= TX_IDLE;
            end else if (coll_over) begin
              tx_status_q[TS_COLL_LIMIT] <= 1'b1;
              tx_status_q[TS_DROPPED] <= 1'b1;
              tx_status_q[TS_OWNER] <= 1'b0;
              tx_done_q <= 1'b1;
              state_q <= TX_IDLE;
            end else begin
              tx_retry_q <= 1'b1;
              sent_q <= 16'h0000;
            end
          end else if (tx_underrun_pulse) begin
            // Underrun: drop if late, else retry
            tx_status_q[TS_FIFO_STARVED] <= 1'b1;
            if (late_coll) begin
              tx_status_q[TS_DROPPED] <= 1'b1;
              tx_status_q[TS_OWNER] <= 1'b0;
              tx_done_q <= 1'b1;
              state_q <= TX_IDLE;
            end else begin
              tx_retry_q <= 1'b1;
              sent_q <= 16'h0000;
            end
          end else if (tx_end_pulse) begin
            tx_status_q[TS_OWNER] <= 1'b0;
            tx_done_q <= 1'b1;
            state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Overrun keeps discard until cleared
  ovr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_flags[EV_RX_OVERRUN] |=> rx_discard_q)
    else $error("discard not held during overrun");
  txdone_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done_q |=> ev_flags[EV_TX_DONE])
    else $error("tx done flag not set");
  mgmt_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    mgmt_rise |=> ev_flags[EV_MGMT_DONE])
    else $error("management flag not set");
  irq_track_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_flags != 8'h00) |-> ##[1:2] irq_q)
    else $error("interrupt missing");
  owner_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done_q |-> !tx_status_q[TS_OWNER])
    else $error("owner still set at done");
  coll_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == TX_SEND && coll_rise && !late_coll && coll_over)
    |=> tx_status_q[TS_COLL_LIMIT] && tx_status_q[TS_DROPPED] && state_q == TX_IDLE)
    else $error("collision limit abort wrong");
  early_retry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == TX_SEND && coll_rise && !late_coll && !coll_over) |=> tx_retry_q)
    else $error("early collision not retried");
  pause_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pause_pulse |=> ev_flags[EV_RX_PAUSE])
    else $error("pause flag not set");
endmodule
`default_nettype wire

// *** hdl/mac_status_pkg.sv ***
// Package for the MAC event status and descriptor status block.
// Assumes a single 100 MHz pclk domain and an APB register bus.
package mac_status_pkg;
  // Register byte addresses
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h00;
  localparam logic [7:0] OFF_AREA_TX_START = 8'h04;
  localparam logic [7:0] OFF_AREA_RX_START = 8'h08;
  localparam logic [7:0] OFF_AREA_RX_END = 8'h0c;
  localparam logic [7:0] OFF_BUF_SIZE = 8'h10;
  localparam logic [7:0] OFF_MAX_FRAME = 8'h14;
  localparam logic [7:0] OFF_CONFIG_TWO = 8'h18;
  localparam logic [7:0] OFF_CONFIG_THREE = 8'h1c;
  localparam logic [7:0] OFF_TX_STATUS = 8'h20;
  localparam logic [7:0] OFF_AUTO_FCS = 8'h24;
  // Event status bit positions
  localparam int EV_TX_DONE = 0;
  localparam int EV_TX_CTRL = 1;
  localparam int EV_RX_OVERRUN = 2;
  localparam int EV_RX_DONE = 3;
  localparam int EV_RX_PAUSE = 4;
  localparam int EV_RX_PACKET = 5;
  localparam int EV_MGMT_DONE = 6;
  localparam int EV_TX_FAULT = 7;
  // Transmit descriptor status bit positions
  localparam int TS_OWNER = 15;
  localparam int TS_DROPPED = 14;
  localparam int TS_BACKPRESSURE = 13;
  localparam int TS_OVERSIZE = 12;
  localparam int TS_LEN_RANGE = 11;
  localparam int TS_LEN_MISMATCH = 10;
  localparam int TS_BAD_FCS = 9;
  localparam int TS_DEFERRED = 8;
  localparam int TS_EXCESS_DEFER = 7;
  localparam int TS_FIFO_STARVED = 6;
  localparam int TS_LATE_COLL = 5;
  localparam int TS_COLL_LIMIT = 4;
  // Buffer size field position
  localparam int BUF_SIZE_LSB = 6;
  // Reset values
  localparam logic [23:0] RST_POINTER = 24'h000000;
  localparam logic [7:0] RST_BUF_SIZE = 8'h00;
  localparam logic [15:0] RST_MAX_FRAME = 16'h05ee;
  localparam logic [5:0] RST_LATE_LIMIT = 6'h38;
  localparam logic [3:0] RST_COLL_LIMIT = 4'hf;
  // Length/type limit and descriptor layout
  localparam logic [15:0] LEN_TYPE_MAX = 16'h05ee;
  localparam int DESC_BYTES = 7;
  localparam int FCS_BYTES = 4;
  // Excess deferral limits in media units, and nibble/bit periods
  localparam int DEFER_NIBBLES_100 = 6071;
  localparam int DEFER_BITS_10 = 24287;
  localparam int NIBBLE_NS_100 = 40;
  localparam int BIT_NS_10 = 100;
  localparam int CLK_NS = 10;
  localparam int DEFER_CYC_100 = (DEFER_NIBBLES_100 * NIBBLE_NS_100) / CLK_NS;
  localparam int DEFER_CYC_10 = (DEFER_BITS_10 * BIT_NS_10) / CLK_NS;
  // Transmit status machine states
  typedef enum logic [1:0] {TX_IDLE, TX_DEFER, TX_SEND} tx_state_type;
endpackage

// *** hdl/pin_sync.sv ***
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are levels from outside the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First flop feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** hdl/event_flags.sv ***
// Sticky event flags: hardware set wins over a software clear.
// Assumes set and clear pulses come from the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module event_flags #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic [WIDTH-1:0] clear_mask,
  output logic [WIDTH-1:0] flags_q,
  output logic any_q
);
  logic [WIDTH-1:0] flags_d;

  // Per-bit sticky logic
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign flags_d[i] = set_pulse[i] | (flags_q[i] & ~clear_mask[i]);
    end
  endgenerate

  // Flag storage and summary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
      any_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      any_q <= |flags_d;
    end
  end
endmodule
`default_nettype wire

// *** dv/phy_model.sv ***
// PHY stand-in: carrier, collision and management-done lines.
// Assumes the bench drives it through its tasks by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  output logic carrier_pin,
  output logic collision_pin,
  output logic mgmt_done_pin
);
  logic link_clk = 1'b0;
  logic run = 1'b0;
  ////////////////////////////////////////
  // Link clock runs only while carrier is on or a set_carrier or collide task runs
  always begin
    wait (run);
    #62.5 link_clk = ~link_clk;
  end
  // Lines idle low, as if tied to ground
  initial begin
    carrier_pin = 1'b0;
    collision_pin = 1'b0;
    mgmt_done_pin = 1'b0;
  end
  ////////////////////////////////////////
  // Carrier changes on a link clock edge
  task automatic set_carrier(input logic on);
    run = 1'b1;
    @(posedge link_clk) carrier_pin = on;
    run = on;
  endtask
  // One collision burst of two link clocks
  task automatic collide();
    run = 1'b1;
    @(posedge link_clk) collision_pin = 1'b1;
    repeat (2) @(posedge link_clk);
    collision_pin = 1'b0;
    repeat (2) @(posedge link_clk);
    run = carrier_pin;
  endtask
  // Management transfer end shown as a level
  task automatic mgmt_done(input logic lvl);
    mgmt_done_pin = lvl;
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the MAC event and transmit status block.
// Assumes APB on pclk and the PHY model on the far side.
`timescale 1ns/1ps
`default_nettype none
module tb import mac_status_pkg::*;;
  localparam int TO_MAX = 20000;
  localparam int D100 = 40;
  localparam int D10 = 80;
  localparam logic [31:0] RST_TAB [10] = '{0, 0, 0, 0, 0, 32'h5ee, 32'h38, 32'hf, 0, 1};
  localparam int EVB [6] = '{1, 2, 3, 4, 5, 7};
  localparam int DLY [3] = '{15, 70, 50};
  localparam int LIM [3] = '{D100, D100, D10};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic tx_fcs_ok, speed_100, carrier_pin, collision_pin, mgmt_done_pin;
  logic irq_q, rx_discard_q, tx_retry_q, tx_done_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, wd;
  logic [15:0] pu, tx_byte_count, tx_len_type, tx_data_bytes, tx_status_q, c, l, d;
  logic [1:0] buf_size_sel_q;
  logic [8:0] buf_bytes_q;
  logic [23:0] tx_area_start_pointer, rx_area_start_pointer, rx_area_end_pointer;
  logic [23:0] lw [4];
  logic f, af;
  int n_fail, checks, cyc, seed, n_retry, n_done;
  mac_status_top #(.DEFER_100(D100), .DEFER_10(D10)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_fault_pulse(pu[7]), .mgmt_done_pin, .tx_ctrl_sent_pulse(pu[1]),
    .rx_ctrl_done_pulse(pu[3]), .rx_pause_pulse(pu[4]), .rx_packet_pulse(pu[5]),
    .rx_fifo_full_pulse(pu[2]), .tx_start_pulse(pu[8]), .tx_byte_count, .tx_len_type,
    .tx_data_bytes, .tx_fcs_ok, .tx_byte_pulse(pu[10]), .tx_underrun_pulse(pu[11]),
    .tx_backpressure_pulse(pu[12]), .speed_100, .carrier_pin, .collision_pin,
    .tx_end_pulse(pu[9]), .irq_q, .rx_discard_q, .tx_retry_q, .tx_done_q, .tx_status_q,
    .buf_size_sel_q, .buf_bytes_q, .tx_area_start_pointer, .rx_area_start_pointer,
    .rx_area_end_pointer
  );
  phy_model phy (.carrier_pin, .collision_pin, .mgmt_done_pin);
  ////////////////////////////////////////
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    // Count one-cycle done and retry pulses while they stand
    if (tx_retry_q === 1'b1) n_retry++;
    if (tx_done_q === 1'b1) n_done++;
    if (cyc == TO_MAX) begin
      n_fail++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  // Compare, report and close
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One APB transfer; waits for pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One-cycle pulse on a numbered event line
  task automatic pulse(input int b);
    @(posedge pclk);
    pu <= 16'h0001 << b;
    @(posedge pclk);
    pu <= 16'h0000;
  endtask
  // Expected error bits of a finished packet
  function automatic logic [15:0] tx_exp(input logic [15:0] bc, lt, db, input logic ok, au);
    tx_exp = 16'h0000;
    tx_exp[12] = bc > RST_MAX_FRAME;
    tx_exp[11] = lt > LEN_TYPE_MAX;
    tx_exp[10] = (lt <= LEN_TYPE_MAX) && (lt != db);
    tx_exp[9] = !au && !ok;
  endfunction
  // Start a packet and see the MAC take ownership
  task automatic tx_run(input logic [15:0] bc, lt, db, input logic ok);
    @(posedge pclk);
    tx_byte_count <= bc;
    tx_len_type <= lt;
    tx_data_bytes <= db;
    tx_fcs_ok <= ok;
    pulse(8);
    repeat (2) @(posedge pclk);
    chk({31'h0, tx_status_q[15]}, 32'h1);
  endtask
  // End a packet, then check release and the done flag
  task automatic tx_fin();
    pulse(9);
    repeat (3) @(posedge pclk);
    chk({31'h0, tx_status_q[15]}, 32'h0);
    apb(1'b0, OFF_EVENT_STATUS, 32'h0);
    chk(rdv & 32'h1, 32'h1);
    apb(1'b1, OFF_EVENT_STATUS, 32'hff);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pu, tx_fcs_ok} = '0;
    {tx_byte_count, tx_len_type, tx_data_bytes} = '0;
    speed_100 = 1'b1;
    presetn = 1'b0;
    seed = 31771;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rdv, RST_TAB[i]);
    end
    apb(1'b0, 8'h28, 32'h0);
    chk({rdv[30:0], rerr}, 32'h1);
    $display("test reset done");
    for (int i = 1; i < 4; i++) begin
      wd = $random(seed);
      lw[i] = wd[23:0];
      apb(1'b1, 8'(i * 4), wd);
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rdv, {8'h00, lw[i]});
    end
    chk({8'h00, tx_area_start_pointer}, {8'h00, lw[1]});
    chk({8'h00, rx_area_start_pointer}, {8'h00, lw[2]});
    chk({8'h00, rx_area_end_pointer}, {8'h00, lw[3]});
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFF_BUF_SIZE, 32'(s) << 6);
      repeat (2) @(posedge pclk);
      chk({21'h0, buf_size_sel_q, buf_bytes_q}, (32'(s) << 9) | (32'h20 << s));
    end
    $display("test layout done");
    foreach (EVB[k]) begin
      pulse(EVB[k]);
      repeat (3) @(posedge pclk);
      apb(1'b0, OFF_EVENT_STATUS, 32'h0);
      chk(rdv, 32'h1 << EVB[k]);
      chk({30'h0, irq_q, rx_discard_q}, {30'h0, 1'b1, EVB[k] == 2});
      apb(1'b1, OFF_EVENT_STATUS, 32'h1 << EVB[k]);
      repeat (3) @(posedge pclk);
      chk({30'h0, irq_q, rx_discard_q}, 32'h0);
    end
    phy.mgmt_done(1'b1);
    repeat (6) @(posedge pclk);
    apb(1'b0, OFF_EVENT_STATUS, 32'h0);
    chk(rdv, 32'h40);
    phy.mgmt_done(1'b0);
    apb(1'b1, OFF_EVENT_STATUS, 32'h40);
    $display("test events done");
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed)) & 16'h07ff;
      c = (i < 2) ? 16'h05ee + 16'(i) : 16'($random(seed)) & 16'h07ff;
      l = (i < 2) ? c : ((($random(seed) & 1) != 0) ? d : 16'($random(seed)) & 16'h0fff);
      f = 1'($random(seed));
      af = 1'($random(seed));
      apb(1'b1, OFF_AUTO_FCS, {31'h0, af});
      tx_run(c, l, d, f);
      tx_fin();
      chk({16'h0, tx_status_q & 16'h1e00}, {16'h0, tx_exp(c, l, d, f, af)});
    end
    $display("test frame checks done");
    for (int i = 0; i < 3; i++) begin
      speed_100 <= (i < 2);
      phy.set_carrier(1'b1);
      repeat (4) @(posedge pclk);
      tx_run(16'h0040, 16'h0800, 16'h0000, 1'b1);
      repeat (DLY[i]) @(posedge pclk);
      phy.set_carrier(1'b0);
      // Let the synchronised carrier fall before the end pulse
      repeat (4) @(posedge pclk);
      tx_fin();
      chk({16'h0, tx_status_q & 16'h0180}, {24'h000001, DLY[i] > LIM[i], 7'h00});
    end
    $display("test deferral done");
    apb(1'b1, OFF_CONFIG_THREE, 32'h2);
    tx_run(16'h0040, 16'h0800, 16'h0000, 1'b1);
    repeat (3) phy.collide();
    repeat (4) @(posedge pclk);
    chk({16'h0, tx_status_q & 16'h401f}, 32'h4013);
    tx_fin();
    apb(1'b1, OFF_CONFIG_THREE, 32'hf);
    apb(1'b1, OFF_CONFIG_TWO, 32'h4);
    tx_run(16'h0040, 16'h0800, 16'h0000, 1'b1);
    repeat (5) pulse(10);
    phy.collide();
    repeat (4) @(posedge pclk);
    chk({16'h0, tx_status_q & 16'h4020}, 32'h4020);
    tx_fin();
    tx_run(16'h0040, 16'h0800, 16'h0000, 1'b1);
    pulse(11);
    pulse(12);
    repeat (3) @(posedge pclk);
    chk({16'h0, tx_status_q & 16'h6040}, 32'h2040);
    tx_fin();
    // Underrun after the late limit drops the packet
    tx_run(16'h0040, 16'h0800, 16'h0000, 1'b1);
    repeat (5) pulse(10);
    pulse(11);
    repeat (3) @(posedge pclk);
    chk({16'h0, tx_status_q & 16'h4040}, 32'h4040);
    tx_fin();
    $display("test collisions done");
    chk(32'(n_retry), 32'h3);
    chk(32'(n_done), 32'hf);
    complete_run();
  end
endmodule
`default_nettype wire
